// ### logic/ipef_pkg.sv
// Purpose: Shared constants and types of the interrupt priority and external edge flag block.
// Assumes: Register indices times four give the Wishbone byte address.
// Notes:   Operation summary follows.
//
// Operation
// - An enable bit blocks or passes the converter interrupt request.
// - Six group levels, each from one high-register bit and one low-register bit.
// - A selected edge on pin 0 to 7 sets that pin's low flag.
// - Low pin flags clear only by writing zero; acknowledge leaves them set.
// - Writing one to any pending flag leaves it unchanged.
// - Edge field 00 none, 01 rising, 10 falling, 11 both edges.
// - Pins 4 to 7 polarity fields, pin 7 in bits 7:6, pin 4 in 1:0.
// - Pins 0 to 3 polarity fields, pin 3 in bits 7:6, pin 0 in 1:0.
// - High polarity register holds pins 12, 11, 10, 8 from top down.
// - Timer 0 overflow sets bit 7 of the timer flag register.
// - Timer 0 match sets bit 6; timer 3 interrupt sets bit 5.
// - Timer flags clear by writing zero or by acknowledge of their source.
// - Bits 3:0 latch pin 12, 11, 10, 8 edges from top down; bit 4 unused.
// - Those pin flags clear by writing zero or by acknowledge of their source.
// - Twenty-four sources form six groups of four sharing one level.
// - Equal level serves lower source first; only higher level preempts service.
// - Global enable zero blocks every request; one lets enabled sources request.
package ipef_pkg;

  localparam int NUM_SRC    = 24;
  localparam int NUM_GROUPS = 6;
  localparam int NUM_PINS   = 12;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_POL_0_3    = 8'hA4;
  localparam logic [7:0] IDX_POL_4_7    = 8'hA5;
  localparam logic [7:0] IDX_EXT_TIMER  = 8'hA6;
  localparam logic [7:0] IDX_POL_8_12   = 8'hA7;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA9;
  localparam logic [7:0] IDX_PRIO_LOW   = 8'hB8;
  localparam logic [7:0] IDX_EXT_LOW    = 8'hC0;
  localparam logic [7:0] IDX_PRIO_HIGH  = 8'hF8;

  // Reset values.
  localparam logic [7:0]  RST_REG8   = 8'h00;
  localparam logic [5:0]  RST_PRIO   = 6'h00;
  localparam logic [23:0] RST_ENABLE = 24'h000000;

  // Bit positions and masks.
  localparam int          GLOBAL_EN_BIT    = 31;
  localparam int          TF_T0_OVF        = 7;
  localparam int          TF_T0_MATCH      = 6;
  localparam int          TF_T3            = 5;
  localparam logic [7:0]  TIMER_FLAG_MASK  = 8'hEF;
  localparam int          ST_REQ_BIT       = 7;
  localparam int          ST_INSVC_LSB     = 8;

  // Source numbers of the sources whose pending flags live here, and of the converter.
  localparam logic [4:0] SRC_EINT10   = 5'h00;
  localparam logic [4:0] SRC_EINT11   = 5'h01;
  localparam logic [4:0] SRC_EXT_IRQ_PIN_7  = 5'h05;
  localparam logic [4:0] SRC_EINT8    = 5'h06;
  localparam logic [4:0] SRC_EINT12   = 5'h0B;
  localparam logic [4:0] SRC_T0_OVF   = 5'h0C;
  localparam logic [4:0] SRC_T0_MATCH = 5'h0D;
  localparam logic [4:0] SRC_T3       = 5'h10;
  localparam logic [4:0] SRC_ADC      = 5'h12;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } ipef_edge_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ipef_wb_req_t;

  typedef struct packed {
    logic t0_overflow;
    logic t0_match;
    logic t3_match;
  } ipef_timer_ev_t;

  typedef struct packed {
    logic                primed;
    logic [NUM_PINS-1:0] sample;
    logic [NUM_PINS-1:0] prev;
  } ipef_edge_state_t;

  typedef struct packed {
    logic [7:0]  pol_0_3;
    logic [7:0]  pol_4_7;
    logic [7:0]  pol_8_12;
    logic [5:0]  prio_low;
    logic [5:0]  prio_high;
    logic [7:0]  ext_low;
    logic [7:0]  ext_timer;
    logic [23:0] enable;
    logic        global_en;
    logic [3:0]  in_service;
    logic        irq_req;
    logic [4:0]  irq_vec;
    logic        wb_ack;
    logic [31:0] rdata;
  } ipef_state_t;

endpackage

// ### logic/ipef_edge_detect.sv
// Purpose: Samples the twelve external pins and flags their selected edges.
// Assumes: Pins are synchronous to clk_i.
// Notes:   Pin order is 0..7, 8, 10, 11, 12; no event in the first cycle after reset.
`timescale 1ns/1ps
module ipef_edge_detect
  import ipef_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Pins and edge selection
  input  wire logic [NUM_PINS-1:0]   pin_i,
  input  wire logic [2*NUM_PINS-1:0] edge_sel_i,
  // Edge events, one cycle each
  output logic      [NUM_PINS-1:0]   event_o
);

  ipef_edge_state_t s;
  ipef_edge_state_t next_s;

  always_comb begin
    next_s        = s;
    next_s.sample = pin_i;
    // The first sample after reset seeds both stages, so a pin resting high makes no edge.
    next_s.prev   = s.primed ? s.sample : pin_i;
    next_s.primed = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      case (ipef_edge_t'(edge_sel_i[2*p +: 2]))
        EDGE_RISE: event_o[p] = s.primed & s.sample[p] & ~s.prev[p];
        EDGE_FALL: event_o[p] = s.primed & ~s.sample[p] & s.prev[p];
        EDGE_BOTH: event_o[p] = s.primed & (s.sample[p] ^ s.prev[p]);
        default:   event_o[p] = 1'b0;
      endcase
    end
  end

endmodule

// ### logic/ipef_top.sv
// Purpose: Interrupt priority selection, external edge flags and timer pending flags.
// Assumes: Classic Wishbone slave, registers in the low byte lane except enable (four lanes) and status (two lanes).
// Notes:   Other peripherals supply level pending requests on periph_irq_i.
`timescale 1ns/1ps
module ipef_top
  import ipef_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // Wishbone slave
  input  wire ipef_wb_req_t        wb_req_i,
  output logic        [31:0]       wb_dat_o,
  output logic                     wb_ack_o,
  // Event sources
  input  wire logic   [NUM_PINS-1:0] ext_irq_pin_i,
  input  wire ipef_timer_ev_t      timer_ev_i,
  input  wire logic   [NUM_SRC-1:0] periph_irq_i,
  // CPU core
  input  wire logic                irq_ack_i,
  input  wire logic   [4:0]        irq_ack_src_i,
  input  wire logic                irq_return_i,
  output logic                     irq_req_o,
  output logic        [4:0]        irq_vec_o
);

  ipef_state_t         s;
  ipef_state_t         next_s;
  logic [NUM_PINS-1:0] pin_event;
  logic                access;
  logic                wr_lane0;
  logic [7:0]          clr_low;
  logic [7:0]          clr_timer;
  logic [7:0]          set_timer;
  logic [7:0]          ack_clr;
  logic [NUM_SRC-1:0]  pending;
  logic [NUM_SRC-1:0]  active;
  logic                found;
  logic [1:0]          best_lvl;
  logic [4:0]          best_src;
  logic                allowed;
  logic [1:0]          cur_lvl;

  // Level of the group that owns a source; groups are source number modulo six.
  function automatic logic [1:0] src_level(input logic [4:0] src,
                                           input logic [5:0] hi,
                                           input logic [5:0] lo);
    logic [2:0] grp;
    grp = 3'(src % 5'(NUM_GROUPS));
    return {hi[grp], lo[grp]};
  endfunction

  // Index of the highest in-service level.
  function automatic logic [1:0] top_level(input logic [3:0] insvc);
    logic [1:0] lvl;
    lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (insvc[i]) begin
        lvl = 2'(i);
      end
    end
    return lvl;
  endfunction

  // Timer flag bits cleared by acknowledge of a source.
  function automatic logic [7:0] ack_mask(input logic [4:0] src);
    logic [7:0] m;
    m = 8'h00;
    if (src == SRC_T0_OVF) begin
      m[TF_T0_OVF] = 1'b1;
    end else if (src == SRC_T0_MATCH) begin
      m[TF_T0_MATCH] = 1'b1;
    end else if (src == SRC_T3) begin
      m[TF_T3] = 1'b1;
    end else if (src == SRC_EINT8) begin
      m[0] = 1'b1;
    end else if (src == SRC_EINT10) begin
      m[1] = 1'b1;
    end else if (src == SRC_EINT11) begin
      m[2] = 1'b1;
    end else if (src == SRC_EINT12) begin
      m[3] = 1'b1;
    end
    return m;
  endfunction

  // Polarity fields packed pin 0 at the bottom through pin 12 at the top.
  ipef_edge_detect u_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .pin_i      (ext_irq_pin_i),
    .edge_sel_i ({s.pol_8_12, s.pol_4_7, s.pol_0_3}),
    .event_o    (pin_event)
  );

  always_comb begin
    access    = wb_req_i.cyc & wb_req_i.stb & ~s.wb_ack;
    wr_lane0  = access & wb_req_i.we & wb_req_i.sel[0];
    clr_low   = 8'h00;
    clr_timer = 8'h00;
    if (wr_lane0 && wb_req_i.adr[9:2] == IDX_EXT_LOW) begin
      clr_low = ~wb_req_i.dat[7:0];
    end
    if (wr_lane0 && wb_req_i.adr[9:2] == IDX_EXT_TIMER) begin
      clr_timer = ~wb_req_i.dat[7:0];
    end
    ack_clr   = irq_ack_i ? ack_mask(irq_ack_src_i) : 8'h00;
    set_timer = {timer_ev_i.t0_overflow, timer_ev_i.t0_match, timer_ev_i.t3_match, 1'b0,
                 pin_event[11], pin_event[10], pin_event[9], pin_event[8]};
  end

  // Pending vector: local flags replace the peripheral lines of their sources.
  always_comb begin
    pending               = periph_irq_i;
    pending[SRC_EINT10]   = s.ext_timer[1];
    pending[SRC_EINT11]   = s.ext_timer[2];
    pending[SRC_EXT_IRQ_PIN_7]  = |s.ext_low;
    pending[SRC_EINT8]    = s.ext_timer[0];
    pending[SRC_EINT12]   = s.ext_timer[3];
    pending[SRC_T0_OVF]   = s.ext_timer[TF_T0_OVF];
    pending[SRC_T0_MATCH] = s.ext_timer[TF_T0_MATCH];
    pending[SRC_T3]       = s.ext_timer[TF_T3];
    // Converter request passes only with its enable bit set.
    active = pending & s.enable & {NUM_SRC{s.global_en}};
  end

  always_comb begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_src = 5'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Strict compare keeps the lower source on a level tie.
      if (active[i] && (!found || src_level(5'(i), s.prio_high, s.prio_low) > best_lvl)) begin
        found    = 1'b1;
        best_lvl = src_level(5'(i), s.prio_high, s.prio_low);
        best_src = 5'(i);
      end
    end
    cur_lvl = top_level(s.in_service);
    allowed = ~(|s.in_service) | (best_lvl > cur_lvl);
  end

  always_comb begin
    next_s        = s;
    next_s.wb_ack = access;
    if (access) begin
      next_s.rdata = 32'h00000000;
      if (wb_req_i.adr[9:2] == IDX_POL_0_3) begin
        next_s.rdata[7:0] = s.pol_0_3;
      end else if (wb_req_i.adr[9:2] == IDX_POL_4_7) begin
        next_s.rdata[7:0] = s.pol_4_7;
      end else if (wb_req_i.adr[9:2] == IDX_EXT_TIMER) begin
        next_s.rdata[7:0] = s.ext_timer;
      end else if (wb_req_i.adr[9:2] == IDX_POL_8_12) begin
        next_s.rdata[7:0] = s.pol_8_12;
      end else if (wb_req_i.adr[9:2] == IDX_IRQ_ENABLE) begin
        next_s.rdata[23:0]          = s.enable;
        next_s.rdata[GLOBAL_EN_BIT] = s.global_en;
      end else if (wb_req_i.adr[9:2] == IDX_IRQ_STATUS) begin
        next_s.rdata[4:0]                       = s.irq_vec;
        next_s.rdata[ST_REQ_BIT]                = s.irq_req;
        next_s.rdata[ST_INSVC_LSB +: 4]         = s.in_service;
      end else if (wb_req_i.adr[9:2] == IDX_PRIO_LOW) begin
        next_s.rdata[5:0] = s.prio_low;
      end else if (wb_req_i.adr[9:2] == IDX_EXT_LOW) begin
        next_s.rdata[7:0] = s.ext_low;
      end else if (wb_req_i.adr[9:2] == IDX_PRIO_HIGH) begin
        next_s.rdata[5:0] = s.prio_high;
      end
    end

    if (wr_lane0) begin
      if (wb_req_i.adr[9:2] == IDX_POL_0_3) begin
        next_s.pol_0_3 = wb_req_i.dat[7:0];
      end else if (wb_req_i.adr[9:2] == IDX_POL_4_7) begin
        next_s.pol_4_7 = wb_req_i.dat[7:0];
      end else if (wb_req_i.adr[9:2] == IDX_POL_8_12) begin
        next_s.pol_8_12 = wb_req_i.dat[7:0];
      end else if (wb_req_i.adr[9:2] == IDX_PRIO_LOW) begin
        next_s.prio_low = wb_req_i.dat[5:0];
      end else if (wb_req_i.adr[9:2] == IDX_PRIO_HIGH) begin
        next_s.prio_high = wb_req_i.dat[5:0];
      end
    end
    if (access && wb_req_i.we && wb_req_i.adr[9:2] == IDX_IRQ_ENABLE) begin
      for (int b = 0; b < 3; b++) begin
        if (wb_req_i.sel[b]) begin
          next_s.enable[8*b +: 8] = wb_req_i.dat[8*b +: 8];
        end
      end
      if (wb_req_i.sel[3]) begin
        next_s.global_en = wb_req_i.dat[GLOBAL_EN_BIT];
      end
    end

    // Set wins over a clear in the same cycle.
    next_s.ext_low   = (s.ext_low & ~clr_low) | pin_event[7:0];
    next_s.ext_timer = ((s.ext_timer & ~clr_timer & ~ack_clr) | set_timer)
                       & TIMER_FLAG_MASK;

    // A return retires the highest level before a new acknowledge is recorded.
    if (irq_return_i && |s.in_service) begin
      next_s.in_service[cur_lvl] = 1'b0;
    end
    if (irq_ack_i) begin
      next_s.in_service[src_level(irq_ack_src_i, s.prio_high, s.prio_low)] = 1'b1;
    end

    next_s.irq_req = found & allowed & ~irq_ack_i;
    // The vector moves only with an issued request, so it holds while no request stands.
    next_s.irq_vec = next_s.irq_req ? best_src : s.irq_vec;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s           <= '0;
      s.pol_0_3   <= RST_REG8;
      s.pol_4_7   <= RST_REG8;
      s.pol_8_12  <= RST_REG8;
      s.prio_low  <= RST_PRIO;
      s.prio_high <= RST_PRIO;
      s.ext_low   <= RST_REG8;
      s.ext_timer <= RST_REG8;
      s.enable    <= RST_ENABLE;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign wb_dat_o  = s.rdata;
  assign wb_ack_o  = s.wb_ack;
  assign irq_req_o = s.irq_req;
  assign irq_vec_o = s.irq_vec;

endmodule

// ### sim/ipef_chk.sv
// Purpose: Port-level assertions for the interrupt priority and edge flag block.
// Assumes: One clock domain; the clock enable is high while traffic runs.
// Notes:   Bound to every ipef_top instance.
`timescale 1ns/1ps
module ipef_chk
  import ipef_pkg::*;
(
  // Watched ports
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         ce_i,
  input wire ipef_wb_req_t wb_req_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  input wire logic         irq_ack_i,
  input wire logic         irq_req_o,
  input wire logic [4:0]   irq_vec_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic take;
  logic rd_tf;
  logic rd_prio;
  logic rd_unm;
  assign take    = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i;
  assign rd_tf   = take && !wb_req_i.we && wb_req_i.adr[9:2] == IDX_EXT_TIMER;
  assign rd_prio = take && !wb_req_i.we && wb_req_i.adr[9:2] == IDX_PRIO_LOW;
  assign rd_unm  = take && !wb_req_i.we && wb_req_i.adr[9:2] == 8'h00;

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_answer;
    take |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_ack_cause;
    wb_ack_o |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unm_zero;
    $past(rd_unm) && wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_unm_zero: assert property (p_unm_zero) else $error("unmapped read not zero");
  property p_tf_bit4;
    $past(rd_tf) && wb_ack_o |-> wb_dat_o[4] == 1'h0;
  endproperty
  a_tf_bit4: assert property (p_tf_bit4) else $error("unused flag bit reads one");
  property p_prio_top;
    $past(rd_prio) && wb_ack_o |-> wb_dat_o[31:6] == 26'h0;
  endproperty
  a_prio_top: assert property (p_prio_top) else $error("priority upper bits set");
  property p_ack_drops_req;
    irq_ack_i && ce_i |=> !irq_req_o;
  endproperty
  a_ack_drops_req: assert property (p_ack_drops_req) else $error("request after ack");
  property p_vec_hold;
    !irq_req_o ##1 !irq_req_o |-> $stable(irq_vec_o);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved while idle");
  property p_reset_quiet;
    $past(rst_i) |-> !wb_ack_o && !irq_req_o && irq_vec_o == 5'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule

bind ipef_top ipef_chk u_ipef_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o)
);

// ### sim/ipef_core_model.sv
// Purpose: Behavioural core that acknowledges requests and returns from service.
// Assumes: The bench raises go_i to allow one acknowledge.
// Notes:   The source lines toggle when idle so stale values are never trusted.
`timescale 1ns/1ps
module ipef_core_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic       go_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       ret_i,
  // Block side
  input  wire logic       req_i,
  input  wire logic [4:0] vec_i,
  output logic            ack_o,
  output logic [4:0]      ack_src_o,
  output logic            ret_o
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk_i) begin
    ack_o     <= 1'h0;
    ack_src_o <= rst_i ? 5'h00 : ~ack_src_o;
    ret_o     <= ret_i && !rst_i;
    wait_cnt  <= 4'h0;
    if (!rst_i && go_i && req_i && !ack_o) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == delay_i) begin
        ack_o     <= 1'h1;
        ack_src_o <= vec_i;
      end
    end
  end
endmodule

// ### sim/ipef_tb.sv
// Purpose: Self-checking bench for the interrupt priority and edge flag block.
// Assumes: Clock enable high except in one freeze check; registers reached over classic Wishbone.
// Notes:   Each scenario is one task.
`timescale 1ns/1ps
module tb;
  import ipef_pkg::*;
  logic           clk_i      = 1'h0;
  logic           rst_i      = 1'h1;
  logic           ce         = 1'h1;
  ipef_wb_req_t   wb         = '0;
  ipef_timer_ev_t tmr        = '0;
  logic [11:0]    pins       = '0;
  logic [23:0]    periph     = '0;
  logic           go         = 1'h0;
  logic           ret        = 1'h0;
  logic [3:0]     dly        = 4'h0;
  logic [31:0]    wb_dat_o;
  logic [31:0]    rq;
  logic           wb_ack_o;
  logic           irq_ack;
  logic [4:0]     irq_src;
  logic           irq_ret;
  logic           irq_req_o;
  logic [4:0]     irq_vec_o;
  int             fail_count = 0;
  int             n_tests    = 0;
  int             cyc_cnt    = 0;

  ipef_top u_ipef_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(wb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_irq_pin_i(pins), .timer_ev_i(tmr), .periph_irq_i(periph),
    .irq_ack_i(irq_ack), .irq_ack_src_i(irq_src), .irq_return_i(irq_ret),
    .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o)
  );
  ipef_core_model u_ipef_core_model (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .delay_i(dly), .ret_i(ret), .req_i(irq_req_o),
    .vec_i(irq_vec_o), .ack_o(irq_ack), .ack_src_o(irq_src), .ret_o(irq_ret)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The run is far shorter than this; reaching it means a hang.
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic compare(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    wb <= '{1'h1, 1'h1, we, {idx, 2'h0}, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rq = wb_dat_o;
    compare("bus ack", {31'h0, wb_ack_o}, 32'h1);
    wb <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'h1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'h0, idx, 32'h0);
    compare(what, rq, exp);
  endtask

  task automatic pin_set(input int b, input logic v);
    pins[b] <= v;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic req_chk(input logic r, input logic [4:0] v);
    repeat (4) @(posedge clk_i);
    compare("request", {31'h0, irq_req_o}, {31'h0, r});
    if (r) compare("vector", {27'h0, irq_vec_o}, {27'h0, v});
  endtask

  task automatic ack_once(input logic [3:0] d);
    int n;
    n = 0;
    dly <= d;
    go <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq_ack !== 1'h1 && n < 20);
    go <= 1'h0;
    compare("core ack", {31'h0, irq_ack}, 32'h1);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic ret_once();
    ret <= 1'h1;
    @(posedge clk_i);
    ret <= 1'h0;
  endtask

  task automatic t_reset();
    logic [7:0] idx [9] = '{IDX_POL_0_3, IDX_POL_4_7, IDX_EXT_TIMER, IDX_POL_8_12,
                            IDX_PRIO_LOW, IDX_EXT_LOW, IDX_PRIO_HIGH, IDX_IRQ_ENABLE, 8'h00};
    foreach (idx[i]) rdchk("reset value", idx[i], 32'h0);
    wr(8'h00, 32'hFF);
    rdchk("unmapped", 8'h00, 32'h0);
    $display("done reset");
  endtask

  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      wr(IDX_POL_0_3, i);
      pin_set(0, 1'h1);
      rdchk("rise", IDX_EXT_LOW, {31'h0, i[0]});
      wr(IDX_EXT_LOW, 32'h1);
      rdchk("write one", IDX_EXT_LOW, {31'h0, i[0]});
      wr(IDX_EXT_LOW, 32'h0);
      pin_set(0, 1'h0);
      rdchk("fall", IDX_EXT_LOW, {31'h0, i[1]});
      wr(IDX_EXT_LOW, 32'h0);
      rdchk("cleared", IDX_EXT_LOW, 32'h0);
    end
    wr(IDX_POL_0_3, 32'h0);
    $display("done pins");
  endtask

  task automatic t_table();
    logic [7:0] pi [4] = '{IDX_POL_4_7, IDX_POL_8_12, IDX_POL_8_12, IDX_POL_8_12};
    logic [7:0] pv [4] = '{8'hC0, 8'h01, 8'h04, 8'hC0};
    int         pb [4] = '{7, 8, 9, 11};
    logic [7:0] fi [4] = '{IDX_EXT_LOW, IDX_EXT_TIMER, IDX_EXT_TIMER, IDX_EXT_TIMER};
    logic [7:0] fv [4] = '{8'h80, 8'h01, 8'h02, 8'h08};
    for (int i = 0; i < 4; i++) begin
      wr(pi[i], {24'h0, pv[i]});
      rdchk("polarity", pi[i], {24'h0, pv[i]});
      pin_set(pb[i], 1'h1);
      pin_set(pb[i], 1'h0);
      rdchk("pin flag", fi[i], {24'h0, fv[i]});
      wr(fi[i], 32'h0);
      rdchk("pin clear", fi[i], 32'h0);
      wr(pi[i], 32'h0);
    end
    $display("done table");
  endtask

  task automatic t_timers();
    tmr <= 3'h7;
    @(posedge clk_i);
    tmr <= 3'h0;
    rdchk("timer set", IDX_EXT_TIMER, 32'hE0);
    wr(IDX_EXT_TIMER, 32'hFF);
    rdchk("timer write one", IDX_EXT_TIMER, 32'hE0);
    wr(IDX_EXT_TIMER, 32'h20);
    rdchk("timer write zero", IDX_EXT_TIMER, 32'h20);
    wr(IDX_EXT_TIMER, 32'h0);
    ce  <= 1'h0;
    tmr <= 3'h4;
    @(posedge clk_i);
    ce  <= 1'h1;
    tmr <= 3'h0;
    rdchk("frozen flag", IDX_EXT_TIMER, 32'h0);
    $display("done timers");
  endtask

  task automatic t_irq();
    periph <= 24'h040000;
    wr(IDX_IRQ_ENABLE, 32'h00040000);
    req_chk(1'h0, 5'h00);
    wr(IDX_IRQ_ENABLE, 32'h80000000);
    req_chk(1'h0, 5'h00);
    wr(IDX_IRQ_ENABLE, 32'h80040000);
    req_chk(1'h1, SRC_ADC);
    periph <= '0;
    wr(IDX_POL_0_3, 32'h1);
    wr(IDX_PRIO_HIGH, 32'h10);
    rdchk("priority", IDX_PRIO_HIGH, 32'h10);
    wr(IDX_IRQ_ENABLE, 32'h80011020);
    pin_set(0, 1'h1);
    tmr <= 3'h5;
    @(posedge clk_i);
    tmr <= 3'h0;
    req_chk(1'h1, SRC_T3);
    ack_once(4'h2);
    rdchk("ack clears", IDX_EXT_TIMER, 32'h80);
    req_chk(1'h0, 5'h00);
    ret_once();
    req_chk(1'h1, SRC_EXT_IRQ_PIN_7);
    ack_once(4'h0);
    rdchk("ack keeps", IDX_EXT_LOW, 32'h1);
    req_chk(1'h0, 5'h00);
    wr(IDX_EXT_LOW, 32'h0);
    ret_once();
    req_chk(1'h1, SRC_T0_OVF);
    ack_once(4'h0);
    rdchk("overflow acked", IDX_EXT_TIMER, 32'h0);
    $display("done irq");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_pins();
    t_table();
    t_timers();
    t_irq();
    print_verdict();
  end
endmodule
